/* rtl/asa_top.sv */
// Alarm status aggregator: one 16-bit alarm status word read over
// classic Wishbone, with mask, forced-fault and configuration registers.
// Assumes same-clock fault sources, except three analog level inputs.
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module asa_top
  import asa_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] general_status_reg_i,
  input wire logic [15:0] general_mask_i,
  input wire logic [15:0] modem_status_i,
  input wire logic [15:0] modem_mask_i,
  input wire logic self_diag_fault_i,
  input wire logic oscillator_start_fault_i,
  input wire logic [2:0] frame_check_fault_count_i,
  input wire logic trim_load_done_i,
  input wire logic trim_crc_error_i,
  input wire logic frame_check_fault_i,
  input wire logic watchdog_timeout_fault_i,
  input wire logic reference_voltage_fault_i,
  input wire logic input1_limit_fault_i,
  input wire logic input0_limit_fault_i,
  input wire logic die_temp_limit_fault_i,
  input wire logic over_temp_error_i,
  input wire logic over_temp_warning_i,
  output logic alarm_n_o,
  output logic irq_o
);

  // Byte-lane write merge used by every writable register
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_val,
    input logic [31:0] wdat,
    input logic [3:0] sel,
    input logic [15:0] wr_bits
  );
    logic [15:0] merged;
    merged = old_val;
    if (sel[0]) begin
      merged[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      merged[15:8] = wdat[15:8];
    end
    lane_merge = (merged & wr_bits) | (old_val & ~wr_bits);
  endfunction : lane_merge

  // Bus decode
  logic [5:0] bus_idx;
  logic bus_req;
  logic bus_take;
  logic bus_wr;
  logic bus_rd;
  logic hit_status;
  logic hit_mask;
  logic hit_force;
  logic hit_config;
  logic status_read;

  // Registers
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [15:0] mask_ff;
  logic [15:0] force_ff;
  logic [15:0] config_ff;
  logic trim_not_loaded_ff;

  // Fault sources
  logic [ASA_LIVE_W-1:0] live_async;
  logic [ASA_LIVE_W-1:0] live_sync;
  logic [ASA_STICKY_W-1:0] sticky_set;
  logic [ASA_STICKY_W-1:0] sticky_flag;
  logic general_status_summary;
  logic modem_summary;
  logic [1:0] frame_check_count_view;
  logic [15:0] alarm_fault_status;
  logic [15:0] unmasked_faults;
  logic alarm_active;

  assign bus_idx = wb_adr_i[7:2];
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_take = bus_req & ~ack_ff;
  assign bus_wr = bus_take & wb_we_i;
  assign bus_rd = bus_take & ~wb_we_i;
  assign hit_status = (bus_idx == ASA_IDX_STATUS);
  assign hit_mask = (bus_idx == ASA_IDX_MASK);
  assign hit_force = (bus_idx == ASA_IDX_FORCE);
  assign hit_config = (bus_idx == ASA_IDX_CONFIG);
  assign status_read = bus_rd & hit_status;

  // Live analog inputs cross into the clock domain
  assign live_async[2] = reference_voltage_fault_i;
  assign live_async[1] = over_temp_error_i;
  assign live_async[0] = over_temp_warning_i;

  asa_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(live_async),
    .sync_o(live_sync)
  );

  // Sticky faults cleared by a status read
  assign sticky_set[2] = trim_crc_error_i;
  assign sticky_set[1] = frame_check_fault_i;
  assign sticky_set[0] = watchdog_timeout_fault_i;

  asa_sticky u_sticky (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .set_i(sticky_set),
    .clear_i(status_read),
    .flag_o(sticky_flag)
  );

  // Trim memory not-loaded flag, cleared once for good
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trim_not_loaded_ff <= 1'b1;
    end else if (trim_load_done_i) begin
      trim_not_loaded_ff <= 1'b0;
    end
  end

  // Summaries of the neighbouring status words
  assign general_status_summary =
    |(general_status_reg_i & ~general_mask_i);
  assign modem_summary = |(modem_status_i & ~modem_mask_i);

  // Counter view depends on the configured limit
  always_comb begin
    if (config_ff[ASA_B_LIMIT8]) begin
      frame_check_count_view = frame_check_fault_count_i[2:1];
    end else begin
      frame_check_count_view = frame_check_fault_count_i[1:0];
    end
  end

  // Alarm status word assembly
  always_comb begin
    alarm_fault_status = '0;
    alarm_fault_status[ASA_B_GEN] = general_status_summary;
    alarm_fault_status[ASA_B_MODEM] = modem_summary;
    alarm_fault_status[ASA_B_SDIAG] = self_diag_fault_i;
    alarm_fault_status[ASA_B_OSC] = oscillator_start_fault_i;
    alarm_fault_status[ASA_B_CNT_HI] = frame_check_count_view[1];
    alarm_fault_status[ASA_B_CNT_LO] = frame_check_count_view[0];
    alarm_fault_status[ASA_B_TRIM] = trim_not_loaded_ff;
    alarm_fault_status[ASA_B_TRIM_CRC] = sticky_flag[2];
    alarm_fault_status[ASA_B_FRAME] = sticky_flag[1];
    alarm_fault_status[ASA_B_WDOG] = sticky_flag[0];
    alarm_fault_status[ASA_B_VREF] =
      live_sync[2] | force_ff[ASA_B_VREF];
    alarm_fault_status[ASA_B_IN1] = input1_limit_fault_i;
    alarm_fault_status[ASA_B_IN0] = input0_limit_fault_i;
    alarm_fault_status[ASA_B_DTEMP] = die_temp_limit_fault_i;
    alarm_fault_status[ASA_B_OTERR] =
      live_sync[1] | force_ff[ASA_B_OTERR];
    alarm_fault_status[ASA_B_OTWARN] =
      live_sync[0] | force_ff[ASA_B_OTWARN];
  end

  // Mask gates faults; oscillator, counter and trim not-loaded bits never interrupt
  assign unmasked_faults =
    alarm_fault_status & ~mask_ff & ASA_IRQ_SRC;
  assign irq_o = |unmasked_faults;

  // Alarm held by oscillator failure or unloaded trim memory
  assign alarm_active = (|unmasked_faults)
    | alarm_fault_status[ASA_B_OSC]
    | trim_not_loaded_ff;
  assign alarm_n_o = ~alarm_active;

  // Mask register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_ff <= ASA_MASK_RST;
    end else if (bus_wr && hit_mask) begin
      mask_ff <= lane_merge(mask_ff, wb_dat_i, wb_sel_i, ASA_MASK_WR)
        | ASA_MASK_FIXED;
    end
  end

  // Forced-fault register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      force_ff <= ASA_FORCE_RST;
    end else if (bus_wr && hit_force) begin
      force_ff <= lane_merge(force_ff, wb_dat_i, wb_sel_i, ASA_FORCE_WR);
    end
  end

  // Configuration register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      config_ff <= ASA_CONFIG_RST;
    end else if (bus_wr && hit_config) begin
      config_ff <= lane_merge(config_ff, wb_dat_i, wb_sel_i, ASA_CONFIG_WR);
    end
  end

  // Read data: latched status captured before the clear lands
  always_comb begin
    nxt_rdata = '0;
    unique case (1'b1)
      hit_status: begin
        nxt_rdata[15:0] = alarm_fault_status;
      end
      hit_mask: begin
        nxt_rdata[15:0] = mask_ff;
      end
      hit_force: begin
        nxt_rdata[15:0] = force_ff;
      end
      hit_config: begin
        nxt_rdata[15:0] = config_ff;
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= '0;
    end else if (bus_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // One-cycle acknowledge for every access, mapped or not
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_take;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

endmodule : asa_top

/* shared/asa_pkg.sv */
// Constants for the alarm status aggregator: register indices, reset
// values, field positions and writable-bit masks.
// Assumes a 32-bit classic Wishbone bus whose byte address is 4x index.
package asa_pkg;

  // Register indices (byte address is four times the index)
  localparam logic [5:0] ASA_IDX_STATUS = 6'h20;
  localparam logic [5:0] ASA_IDX_MASK = 6'h30;
  localparam logic [5:0] ASA_IDX_FORCE = 6'h31;
  localparam logic [5:0] ASA_IDX_CONFIG = 6'h32;

  // Reset values
  localparam logic [15:0] ASA_STATUS_RST = 16'h0200;
  localparam logic [15:0] ASA_MASK_RST = 16'hefdf;
  localparam logic [15:0] ASA_FORCE_RST = 16'h0000;
  localparam logic [15:0] ASA_CONFIG_RST = 16'h0000;

  // Writable bits of each register, and bits fixed at one in the mask register
  localparam logic [15:0] ASA_MASK_WR = 16'hf1ff;
  localparam logic [15:0] ASA_MASK_FIXED = 16'h0e00;
  localparam logic [15:0] ASA_FORCE_WR = 16'h0023;
  localparam logic [15:0] ASA_CONFIG_WR = 16'h0001;

  // Status bits that may reach the interrupt request
  localparam logic [15:0] ASA_IRQ_SRC = 16'he1ff;

  // Status field positions
  localparam int ASA_B_GEN = 15;
  localparam int ASA_B_MODEM = 14;
  localparam int ASA_B_SDIAG = 13;
  localparam int ASA_B_OSC = 12;
  localparam int ASA_B_CNT_HI = 11;
  localparam int ASA_B_CNT_LO = 10;
  localparam int ASA_B_TRIM = 9;
  localparam int ASA_B_TRIM_CRC = 8;
  localparam int ASA_B_FRAME = 7;
  localparam int ASA_B_WDOG = 6;
  localparam int ASA_B_VREF = 5;
  localparam int ASA_B_IN1 = 4;
  localparam int ASA_B_IN0 = 3;
  localparam int ASA_B_DTEMP = 2;
  localparam int ASA_B_OTERR = 1;
  localparam int ASA_B_OTWARN = 0;

  // Configuration field: frame check counter limit is eight
  localparam int ASA_B_LIMIT8 = 0;

  // Widths of the sticky and synchronised groups
  localparam int ASA_STICKY_W = 3;
  localparam int ASA_LIVE_W = 3;

endpackage : asa_pkg

/* rtl/asa_sync.sv */
// Two-flop synchroniser for the live analog fault levels.
// Assumes inputs are asynchronous levels held for several clocks.
`timescale 1ns/1ps
module asa_sync
  import asa_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [ASA_LIVE_W-1:0] async_i,
  output logic [ASA_LIVE_W-1:0] sync_o
);

  logic [ASA_LIVE_W-1:0] stage1_ff;
  logic [ASA_LIVE_W-1:0] stage2_ff;

  // First stage is read only by the second stage
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= async_i;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_o = stage2_ff;

endmodule : asa_sync

/* rtl/asa_sticky.sv */
// Sticky fault flags, cleared by a read unless the cause persists.
// Assumes set inputs are levels on the system clock.
`timescale 1ns/1ps
module asa_sticky
  import asa_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [ASA_STICKY_W-1:0] set_i,
  input wire logic clear_i,
  output logic [ASA_STICKY_W-1:0] flag_o
);

  logic [ASA_STICKY_W-1:0] flag_ff;
  logic [ASA_STICKY_W-1:0] nxt_flag;

  // Set wins over a clear in the same cycle
  always_comb begin
    nxt_flag = set_i | (flag_ff & {ASA_STICKY_W{~clear_i}});
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag_o = flag_ff;

endmodule : asa_sticky

/* testbench/asa_top_monitor.sv */
// Checker on the ports of the alarm status aggregator.
// Assumes a bind into asa_top; watches reads of the status word.
`timescale 1ns/1ps
module asa_top_monitor
  import asa_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [15:0] general_status_reg_i,
  input wire logic [15:0] general_mask_i,
  input wire logic self_diag_fault_i,
  input wire logic oscillator_start_fault_i,
  input wire logic trim_load_done_i,
  input wire logic trim_crc_error_i,
  input wire logic frame_check_fault_i,
  input wire logic watchdog_timeout_fault_i,
  input wire logic alarm_n_o,
  input wire logic irq_o
);
  logic loaded_ff;
  logic [2:0] cause_ff;
  logic take, gen_any;
  logic [2:0] cause, held;
  logic [1:0] live2;
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i
    & (wb_adr_i[7:2] == ASA_IDX_STATUS);
  assign gen_any = |(general_status_reg_i & ~general_mask_i);
  assign live2 = {self_diag_fault_i, oscillator_start_fault_i};
  assign cause = {trim_crc_error_i, frame_check_fault_i,
    watchdog_timeout_fault_i};
  assign held = cause_ff & cause;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      loaded_ff <= 1'b0;
      cause_ff <= 3'h0;
    end else begin
      loaded_ff <= loaded_ff | trim_load_done_i;
      cause_ff <= cause;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_take; take; endsequence
  sequence s_ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  a_ack_once: assert property (s_take |=> s_ack_pulse)
    else $error("ack not a single pulse");
  a_gen_summary: assert property (
    take && $stable(general_status_reg_i) && $stable(general_mask_i)
    |=> wb_dat_o[15] == $past(gen_any)) else $error("bit 15 wrong");
  a_live_diag: assert property (take && $stable(live2)
    |=> wb_dat_o[13:12] == $past(live2)) else $error("bits 13:12 wrong");
  a_sticky_keep: assert property (s_take
    |=> (wb_dat_o[8:6] & $past(held)) == $past(held))
    else $error("sticky bit lost");
  a_trim_flag: assert property (take && !trim_load_done_i
    |=> wb_dat_o[9] == !$past(loaded_ff)) else $error("bit 9 wrong");
  a_trim_alarm: assert property (
    !loaded_ff && !trim_load_done_i |-> !alarm_n_o)
    else $error("alarm free before trim load");
  a_osc_alarm: assert property (
    oscillator_start_fault_i |-> !alarm_n_o) else $error("osc no alarm");
  a_irq_alarm: assert property (irq_o |-> !alarm_n_o)
    else $error("irq without alarm");
endmodule : asa_top_monitor

/* testbench/asa_top_tb_top.sv */
// Bench for the alarm status aggregator: Wishbone tasks and scenarios.
// Assumes the package, design files and checker are compiled first.
`timescale 1ns/1ps
module asa_top_tb_top;
  import asa_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, f = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [15:0] gs = 16'h0, gm = 16'h0, ms = 16'h0, mm = 16'h0;
  logic [2:0] cnt = 3'h0, st = 3'h0;
  logic done = 1'b0, ack, alm_n, irq;
  int failures = 0, compares = 0;
  always #20 clk = ~clk;
  asa_top i_asa_top (.sys_clk_i(clk), .reset_n_i(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .general_status_reg_i(gs), .general_mask_i(gm), .modem_status_i(ms),
    .modem_mask_i(mm), .self_diag_fault_i(f[7]),
    .oscillator_start_fault_i(f[6]), .frame_check_fault_count_i(cnt),
    .trim_load_done_i(done), .trim_crc_error_i(st[2]),
    .frame_check_fault_i(st[1]), .watchdog_timeout_fault_i(st[0]),
    .reference_voltage_fault_i(f[5]), .input1_limit_fault_i(f[4]),
    .input0_limit_fault_i(f[3]), .die_temp_limit_fault_i(f[2]),
    .over_temp_error_i(f[1]), .over_temp_warning_i(f[0]),
    .alarm_n_o(alm_n), .irq_o(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (ack !== 1'b1) failures++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, e);
  endtask : rd
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h80, 32'h200);
    chk({31'h0, alm_n}, 32'h0);
    $display("reset test done");
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    rd(8'h80, 32'h0);
    chk({31'h0, alm_n}, 32'h1);
    bus(1'b1, 8'h80, 16'hffff);
    rd(8'h80, 32'h0);
    rd(8'h10, 32'h0);
    $display("trim test done");
    @(posedge clk);
    st <= 3'h7;
    repeat (2) @(posedge clk);
    st <= 3'h1;
    rd(8'h80, 32'h1c0);
    rd(8'h80, 32'h040);
    @(posedge clk);
    st <= 3'h0;
    rd(8'h80, 32'h040);
    rd(8'h80, 32'h0);
    $display("sticky test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      f <= 8'h01 << i;
      repeat (4) @(posedge clk);
      rd(8'h80, {18'h0, f[7:6], 6'h0, f[5:0]});
      chk({31'h0, alm_n}, {31'h0, i != 5 && i != 6});
      chk({31'h0, irq}, {31'h0, i == 5});
    end
    @(posedge clk);
    f <= 8'h00;
    $display("live test done");
    bus(1'b1, 8'hc4, 16'h0023);
    rd(8'h80, 32'h23);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'hc0, 16'hefff);
    rd(8'h80, 32'h23);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, alm_n}, 32'h1);
    bus(1'b1, 8'hc4, 16'h0000);
    $display("mask test done");
    @(posedge clk);
    cnt <= 3'h6;
    rd(8'h80, 32'h800);
    bus(1'b1, 8'hc8, 16'h0001);
    rd(8'h80, 32'hc00);
    @(posedge clk);
    cnt <= 3'h0;
    $display("counter test done");
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      gs <= 16'h0100;
      gm <= j[0] ? 16'h0100 : 16'h0000;
      ms <= 16'h8000;
      mm <= j[1] ? 16'h8000 : 16'h0000;
      rd(8'h80, {16'h0, ~j[0], ~j[1], 14'h0});
    end
    $display("summary test done");
    wrap_up();
  end
endmodule : asa_top_tb_top
bind asa_top asa_top_monitor i_asa_top_monitor (.sys_clk_i, .reset_n_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .general_status_reg_i, .general_mask_i, .self_diag_fault_i,
  .oscillator_start_fault_i, .trim_load_done_i, .trim_crc_error_i,
  .frame_check_fault_i, .watchdog_timeout_fault_i, .alarm_n_o, .irq_o);
